// ### design/cpu_jump_stack_loadstore_ops.sv
// Execution unit for register jumps, stack push/pop, loads, stores and block moves.
// Assumes one command at a time, a word bus whose memory answers with memAck.
`timescale 1ns/1ns
`include "cpu_ops_map.svh"
module cpu_jump_stack_loadstore_ops
  import cpu_ops_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire op_type cmdOp,
  input wire addr_mode_type cmdMode,
  input wire logic [3:0] cmdRegA,
  input wire logic [3:0] cmdRegB,
  input wire logic [3:0] cmdRegIdx,
  input wire logic [3:0] cmdCount,
  input wire logic cmdWithRa,
  input wire logic cmdPairLink,
  input wire logic cmdCondMet,
  input wire logic [23:0] cmdDisp,
  input wire logic [3:0] cmdImm4,
  output logic memReq,
  output logic memWrite,
  output logic [23:0] memAddr,
  output logic [15:0] memWdata,
  input wire logic [15:0] memRdata,
  input wire logic memAck,
  output logic [23:0] pcOut,
  output logic userLevelFlag,
  output logic [15:0] regView [16]
);
  // ---------------------------------------------
  // State
  // ---------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_XFER} state_type;
  state_type state_r;
  logic [15:0] regs_r [16];
  logic [23:0] pc_r;
  logic [23:0] excPc_r;
  logic user_r;
  op_type op_r;
  logic [23:0] addr_r;
  logic [3:0] left_r;
  logic [3:0] curReg_r;
  logic [2:0] blkIdx_r;
  logic raPending_r;
  logic wr_r;
  logic [15:0] wdata_r;
  logic retAfter_r;

  // ---------------------------------------------
  // Address and operand selection
  // ---------------------------------------------
  wire [15:0] regA = regs_r[cmdRegA];
  wire [15:0] regB = regs_r[cmdRegB];
  wire [15:0] regB1 = regs_r[cmdRegB + 4'h1];
  wire [15:0] regIdx = regs_r[cmdRegIdx];
  wire [23:0] pairB = {regB1[7:0], regB};
  wire [23:0] pcNext = pc_r + `NEXT_INSN;
  wire [23:0] ea = (cmdMode == AM_REL) ? {8'h00, regB} + cmdDisp :
                   (cmdMode == AM_ABS) ? cmdDisp :
                   (cmdMode == AM_ABS_IDX) ? cmdDisp + {8'h00, regIdx} :
                   (cmdMode == AM_PAIR_IDX) ? pairB + cmdDisp + {8'h00, regIdx} :
                   pairB + cmdDisp;
  function automatic logic [3:0] blkReg(input logic [2:0] i);
    blkReg = i[2] ? {2'b10, i[1:0]} : {2'b00, i[1:0]} + 4'h2;
  endfunction
  wire [15:0] spVal = regs_r[`REG_SP];
  wire [23:0] blkStart = (cmdOp == OP_BLOCK_LOAD) ? {8'h00, regs_r[`REG_R0]} :
                         (cmdOp == OP_BLOCK_LOAD_PAIR) ? {regs_r[`REG_R1][7:0], regs_r[`REG_R0]} :
                         {8'h00, regs_r[`REG_R2]};
  wire isBlock = cmdOp == OP_BLOCK_LOAD || cmdOp == OP_BLOCK_LOAD_PAIR || cmdOp == OP_BLOCK_STORE;
  wire isStack = cmdOp == OP_PUSH || cmdOp == OP_POP || cmdOp == OP_POP_RET;
  wire accept = cmdValid && state_r == ST_IDLE;
  wire xferDone = state_r == ST_XFER && memAck;
  wire lastBeat = left_r == 4'h1;
  wire [3:0] beatReg = (op_r == OP_BLOCK_LOAD || op_r == OP_BLOCK_LOAD_PAIR || op_r == OP_BLOCK_STORE)
                       ? blkReg(blkIdx_r) : (raPending_r && lastBeat ? `REG_RA : curReg_r);
  wire beatWrite = op_r == OP_PUSH || op_r == OP_STORE_W || op_r == OP_STORE_D
                   || op_r == OP_STORE_IMM || op_r == OP_BLOCK_STORE;
  wire [3:0] nextReg = (op_r == OP_BLOCK_LOAD || op_r == OP_BLOCK_LOAD_PAIR || op_r == OP_BLOCK_STORE)
                       ? blkReg(blkIdx_r + 3'h1) : (raPending_r && left_r == 4'h2 ? `REG_RA : curReg_r + 4'h1);
  wire [3:0] stackCnt = cmdCount + {3'h0, cmdWithRa};
  wire [23:0] pushBase = {8'h00, spVal} - {stackCnt, 1'b0};

  assign cmdReady = state_r == ST_IDLE;
  assign memReq = state_r == ST_XFER;
  assign memWrite = wr_r;
  assign memAddr = addr_r;
  assign memWdata = wdata_r;
  assign pcOut = pc_r;
  assign userLevelFlag = user_r;
  assign regView = regs_r;

  // ---------------------------------------------
  // Sequencer
  // ---------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= ST_IDLE;
      for (int i = 0; i < 16; i++)
        regs_r[i] <= 16'h0000;
      pc_r <= `PC_RESET;
      excPc_r <= `PC_RESET;
      user_r <= 1'b0;
      op_r <= OP_JUMP_COND;
      addr_r <= 24'h000000;
      left_r <= 4'h0;
      curReg_r <= 4'h0;
      blkIdx_r <= 3'h0;
      raPending_r <= 1'b0;
      wr_r <= 1'b0;
      wdata_r <= 16'h0000;
      retAfter_r <= 1'b0;
    end
    else if (accept)
    begin
      op_r <= cmdOp;
      wr_r <= 1'b0;
      retAfter_r <= cmdOp == OP_POP_RET;
      raPending_r <= isStack && cmdWithRa;
      curReg_r <= isBlock ? blkReg(3'h0) : cmdRegA;
      blkIdx_r <= 3'h0;
      case (cmdOp)
        OP_JUMP_COND: pc_r <= cmdCondMet ? pairB : pcNext;
        OP_JUMP_LINK:
        begin
          regs_r[cmdRegA] <= pcNext[15:0];
          if (cmdPairLink)
            regs_r[cmdRegA + 4'h1] <= {8'h00, pcNext[23:16]};
          pc_r <= pairB;
        end
        OP_JUMP_USER:
        begin
          pc_r <= pairB;
          user_r <= 1'b1;
        end
        OP_EXC_RETURN: pc_r <= excPc_r;
        default:
        begin
          state_r <= ST_XFER;
          pc_r <= pcNext;
          if (isStack)
          begin
            left_r <= stackCnt;
            addr_r <= cmdOp == OP_PUSH ? pushBase : {8'h00, spVal};
            wr_r <= cmdOp == OP_PUSH;
            wdata_r <= (cmdWithRa && cmdCount == 4'h0) ? regs_r[`REG_RA] : regA;
            if (cmdOp == OP_PUSH)
              regs_r[`REG_SP] <= pushBase[15:0];
          end
          else if (isBlock)
          begin
            left_r <= {1'b0, cmdCount[2:0]} + 4'h1;
            addr_r <= blkStart;
            wr_r <= cmdOp == OP_BLOCK_STORE;
            wdata_r <= regs_r[blkReg(3'h0)];
          end
          else
          begin
            left_r <= (cmdOp == OP_LOAD_D || cmdOp == OP_STORE_D) ? 4'h2 : 4'h1;
            addr_r <= ea;
            wr_r <= cmdOp == OP_STORE_W || cmdOp == OP_STORE_D || cmdOp == OP_STORE_IMM;
            wdata_r <= cmdOp == OP_STORE_IMM ? {`IMM4_ZERO_PAD, cmdImm4} : regA;
          end
        end
      endcase
    end
    else if (xferDone)
    begin
      if (!beatWrite)
        regs_r[beatReg] <= memRdata;
      addr_r <= addr_r + `WORD_STEP;
      left_r <= left_r - 4'h1;
      curReg_r <= curReg_r + 4'h1;
      blkIdx_r <= blkIdx_r + 3'h1;
      wdata_r <= regs_r[nextReg];
      if (lastBeat)
      begin
        state_r <= ST_IDLE;
        wr_r <= 1'b0;
        if (op_r == OP_POP || op_r == OP_POP_RET)
          regs_r[`REG_SP] <= addr_r[15:0] + 16'h0002;
        if (retAfter_r)
          pc_r <= {8'h00, raPending_r ? memRdata : regs_r[`REG_RA]};
      end
    end
  end

  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  chk_jump_cond_taken: assert property (@(posedge sys_clk) disable iff (!reset_n)
    accept && cmdOp == OP_JUMP_COND && cmdCondMet |=> pc_r == $past(pairB))
    else $error("Conditional jump target wrong");
  chk_jump_cond_fall: assert property (@(posedge sys_clk) disable iff (!reset_n)
    accept && cmdOp == OP_JUMP_COND && !cmdCondMet |=> pc_r == $past(pcNext))
    else $error("Conditional jump fall through wrong");
  chk_link_saved: assert property (@(posedge sys_clk) disable iff (!reset_n)
    accept && cmdOp == OP_JUMP_LINK |=> regs_r[$past(cmdRegA)] == $past(pcNext[15:0]))
    else $error("Link value not saved");
  chk_push_writes: assert property (@(posedge sys_clk) disable iff (!reset_n)
    accept && cmdOp == OP_PUSH |=> memReq && memWrite && memAddr == $past(pushBase))
    else $error("Push does not write at stack");
  chk_pop_reads: assert property (@(posedge sys_clk) disable iff (!reset_n)
    accept && cmdOp == OP_POP |=> memReq && !memWrite && memAddr == $past({8'h00, spVal}))
    else $error("Pop does not read from stack");
  chk_imm_zero_ext: assert property (@(posedge sys_clk) disable iff (!reset_n)
    accept && cmdOp == OP_STORE_IMM |=> memWdata == {12'h000, $past(cmdImm4)} && memWrite)
    else $error("Nibble not zero extended");
  chk_blk_load_base: assert property (@(posedge sys_clk) disable iff (!reset_n)
    accept && cmdOp == OP_BLOCK_LOAD |=> memAddr == {8'h00, $past(regs_r[`REG_R0])})
    else $error("Block load base wrong");
  chk_blk_pair_base: assert property (@(posedge sys_clk) disable iff (!reset_n)
    accept && cmdOp == OP_BLOCK_LOAD_PAIR |=> memAddr == $past({regs_r[`REG_R1][7:0], regs_r[`REG_R0]}))
    else $error("Pair block load base wrong");
  chk_blk_store_base: assert property (@(posedge sys_clk) disable iff (!reset_n)
    accept && cmdOp == OP_BLOCK_STORE |=> memAddr == {8'h00, $past(regs_r[`REG_R2])} && memWrite)
    else $error("Block store base wrong");
  chk_addr_step: assert property (@(posedge sys_clk) disable iff (!reset_n)
    xferDone && !lastBeat |=> memAddr == $past(memAddr) + 24'h000002)
    else $error("Address step wrong");
  chk_load_dest: assert property (@(posedge sys_clk) disable iff (!reset_n)
    xferDone && op_r == OP_LOAD_W |=> regs_r[$past(beatReg)] == $past(memRdata) && cmdReady)
    else $error("Load result not written");
  cov_pop_ret: cover property (@(posedge sys_clk) disable iff (!reset_n) xferDone && lastBeat && retAfter_r);
  cov_blk_full: cover property (@(posedge sys_clk) disable iff (!reset_n) accept && isBlock && cmdCount[2:0] == 3'h7);
  cov_store_d: cover property (@(posedge sys_clk) disable iff (!reset_n) xferDone && op_r == OP_STORE_D);
endmodule

// ### shared/cpu_ops_map.svh
// Constants for the jump, stack and load/store execution unit.
// Assumes a 16-bit register file of sixteen registers and a word bus to memory.
`ifndef CPU_OPS_MAP_SVH
`define CPU_OPS_MAP_SVH
`define REG_R0 4'h0
`define REG_R1 4'h1
`define REG_R2 4'h2
`define REG_RA 4'he
`define REG_SP 4'hf
`define WORD_STEP 24'h000002
`define NEXT_INSN 24'h000004
`define IMM4_ZERO_PAD 12'h000
`define SP_RESET 16'h0000
`define PC_RESET 24'h000000
`endif

// ### shared/cpu_ops_pkg.sv
// Types for the jump, stack and load/store execution unit.
// Assumes the decoder upstream fills in the command fields.
package cpu_ops_pkg;
  typedef enum logic [3:0] {
    OP_JUMP_COND, OP_JUMP_LINK, OP_JUMP_USER, OP_EXC_RETURN,
    OP_PUSH, OP_POP, OP_POP_RET,
    OP_LOAD_W, OP_LOAD_D, OP_STORE_W, OP_STORE_D, OP_STORE_IMM,
    OP_BLOCK_LOAD, OP_BLOCK_LOAD_PAIR, OP_BLOCK_STORE
  } op_type;
  typedef enum logic [2:0] {
    AM_REL, AM_ABS, AM_ABS_IDX, AM_PAIR_IDX, AM_PAIR_REL
  } addr_mode_type;
endpackage

// ### test/mem_model.sv
// Word memory standing on the far side of the core bus.
// Assumes each request is held until memAck is seen.
`timescale 1ns/1ns
module mem_model
(
  input wire logic sys_clk,
  input wire logic memReq,
  input wire logic memWrite,
  input wire logic [23:0] memAddr,
  input wire logic [15:0] memWdata,
  input wire logic [1:0] waitSel,
  output logic [15:0] memRdata,
  output logic memAck
);
  logic [15:0] mem [logic [23:0]];
  int n = 0;
  initial memAck = 1'b0;
  initial memRdata = 16'h0000;
  // Idle read data toggles every cycle
  always @(posedge sys_clk)
  begin
    memAck <= 1'b0;
    memRdata <= ~memRdata;
    if (memReq === 1'b1 && !memAck)
    begin
      if (n < waitSel)
        n++;
      else
      begin
        n = 0;
        memAck <= 1'b1;
        if (memWrite)
          mem[memAddr] = memWdata;
        else
          memRdata <= mem.exists(memAddr) ? mem[memAddr] : memAddr[15:0] ^ 16'h5a5a;
      end
    end
  end
endmodule

// ### test/tb.sv
// Bench for the jump, stack and load/store unit.
// Assumes the memory model answers each beat within four cycles.
`timescale 1ns/1ns
`include "cpu_ops_map.svh"
module tb
  import cpu_ops_pkg::*;
;
  logic sys_clk = 1'b0, reset_n = 1'b0, cmdValid = 1'b0, cmdWithRa = 1'b0, cmdPairLink = 1'b0, cmdCondMet = 1'b0;
  op_type cmdOp = OP_LOAD_W;
  addr_mode_type cmdMode = AM_ABS;
  logic [3:0] cmdRegA = 4'h0, cmdRegB = 4'h0, cmdRegIdx = 4'h0, cmdCount = 4'h0, cmdImm4 = 4'h0;
  logic [23:0] cmdDisp = 24'h000000, pcOut, memAddr, pc;
  logic [15:0] memRdata, memWdata, regView [16], rf [16], refMem [logic [23:0]];
  logic cmdReady, memReq, memWrite, memAck, userLevelFlag, ulf;
  logic [1:0] waitSel = 2'h0;
  logic [39:0] expQ [$];
  int fail_count = 0, checks = 0, cyc = 0, seed = 32'hb8f1;
  initial forever #2 sys_clk = ~sys_clk;
  cpu_jump_stack_loadstore_ops i_cpu_jump_stack_loadstore_ops (.*);
  mem_model i_mem_model (.*);
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic cmpV(input string s, input logic [39:0] e, input logic [39:0] g);
    checks++;
    if (e !== g)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  function automatic logic [23:0] rnd();
    return 24'($random(seed));
  endfunction
  function automatic logic [15:0] rd(input logic [23:0] ad);
    return refMem.exists(ad) ? refMem[ad] : ad[15:0] ^ 16'h5a5a;
  endfunction
  task automatic wr(input logic [23:0] ad, input logic [15:0] v);
    refMem[ad] = v;
    expQ.push_back({ad, v});
  endtask
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      tally_and_finish();
    end
    if (memReq === 1'b1 && memAck === 1'b1 && memWrite === 1'b1)
      cmpV("write", expQ.size() ? expQ.pop_front() : 40'h0, {memAddr, memWdata});
  end
  // Reference model of one command
  task automatic step();
    logic [23:0] pr, ea, nx, bs, sb;
    logic [15:0] sp;
    logic [3:0] ar;
    int n;
    pr = {rf[cmdRegB + 4'h1][7:0], rf[cmdRegB]};
    nx = pc + `NEXT_INSN;
    case (cmdMode)
      AM_REL: ea = rf[cmdRegB] + cmdDisp;
      AM_ABS: ea = cmdDisp;
      AM_ABS_IDX: ea = cmdDisp + rf[cmdRegIdx];
      AM_PAIR_IDX: ea = pr + cmdDisp + rf[cmdRegIdx];
      default: ea = pr + cmdDisp;
    endcase
    n = cmdCount + cmdWithRa;
    sp = (cmdOp == OP_PUSH) ? rf[15] - 16'(2 * n) : rf[15];
    sb = (cmdOp == OP_PUSH) ? {8'h00, rf[15]} - 24'(2 * n) : {8'h00, rf[15]};
    bs = cmdOp == OP_BLOCK_STORE ? rf[2] : cmdOp == OP_BLOCK_LOAD ? rf[0] : {rf[1][7:0], rf[0]};
    pc = nx;
    case (cmdOp)
      OP_JUMP_COND: pc = cmdCondMet ? pr : nx;
      OP_JUMP_USER: {pc, ulf} = {pr, 1'b1};
      OP_EXC_RETURN: pc = `PC_RESET;
      OP_JUMP_LINK:
      begin
        pc = pr;
        if (cmdPairLink)
          rf[cmdRegA + 4'h1] = {8'h00, nx[23:16]};
        rf[cmdRegA] = nx[15:0];
      end
      OP_LOAD_W: rf[cmdRegA] = rd(ea);
      OP_LOAD_D: {rf[cmdRegA + 4'h1], rf[cmdRegA]} = {rd(ea + `WORD_STEP), rd(ea)};
      OP_STORE_W: wr(ea, rf[cmdRegA]);
      OP_STORE_D:
      begin
        wr(ea, rf[cmdRegA]);
        wr(ea + `WORD_STEP, rf[cmdRegA + 4'h1]);
      end
      OP_STORE_IMM: wr(ea, {`IMM4_ZERO_PAD, cmdImm4});
      default: ;
    endcase
    for (int i = 0; i < 8; i++)
      if (cmdOp >= OP_BLOCK_LOAD && i <= cmdCount[2:0])
      begin
        ar = 4'(i < 4 ? i + 2 : i + 4);
        if (cmdOp == OP_BLOCK_STORE)
          wr(bs + 24'(2 * i), rf[ar]);
        else
          rf[ar] = rd(bs + 24'(2 * i));
      end
    for (int i = 0; i < n; i++)
      if (cmdOp inside {OP_PUSH, OP_POP, OP_POP_RET})
      begin
        ar = (i == cmdCount) ? `REG_RA : cmdRegA + 4'(i);
        if (cmdOp == OP_PUSH)
          wr(sb + 24'(2 * i), rf[ar]);
        else
          rf[ar] = rd(sb + 24'(2 * i));
      end
    if (cmdOp inside {OP_PUSH, OP_POP, OP_POP_RET})
      rf[15] = (cmdOp == OP_PUSH) ? sp : sp + 16'(2 * n);
    if (cmdOp == OP_POP_RET)
      pc = {8'h00, rf[`REG_RA]};
  endtask
  task automatic issue(input op_type o, input addr_mode_type m, input logic [3:0] a, b, x, c,
    input logic [23:0] d, input logic [2:0] f);
    int k;
    @(posedge sys_clk);
    cmdOp <= o;
    cmdMode <= m;
    {cmdRegA, cmdRegB, cmdRegIdx, cmdCount} <= {a, b, x, c};
    {cmdWithRa, cmdPairLink, cmdCondMet} <= f;
    cmdDisp <= d;
    cmdImm4 <= 4'($random(seed));
    waitSel <= 2'($random(seed));
    cmdValid <= 1'b1;
    @(posedge sys_clk);
    cmdValid <= 1'b0;
    step();
    k = 0;
    do
    begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    while (cmdReady !== 1'b1 && k < 300);
    cmpV("ready", 1, cmdReady);
    for (int i = 0; i < 16; i++)
      cmpV("reg", rf[i], regView[i]);
    cmpV("pc", pc, pcOut);
    cmpV("user", ulf, userLevelFlag);
    cmpV("pending", 0, expQ.size());
  endtask
  initial
  begin
    for (int i = 0; i < 16; i++)
      rf[i] = 16'h0000;
    pc = `PC_RESET;
    ulf = 1'b0;
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 16; i++)
      issue(OP_LOAD_W, AM_ABS, 4'(i), 0, 0, 0, rnd(), 0);
    $display("fill done");
    for (int m = 0; m < 5; m++)
      for (int o = OP_LOAD_W; o <= OP_STORE_IMM; o++)
        issue(op_type'(o), addr_mode_type'(m), {2'b10, 2'(rnd())}, {1'b0, 3'(rnd())}, {1'b0, 3'(rnd())}, 0,
          rnd(), 0);
    $display("modes done");
    for (int c = 0; c < 8; c++)
      for (int o = OP_BLOCK_LOAD; o <= OP_BLOCK_STORE; o++)
        issue(op_type'(o), AM_ABS, 0, 0, 0, 4'(c), 0, 0);
    $display("block done");
    for (int i = 0; i < 4; i++)
    begin
      issue(OP_PUSH, AM_ABS, {1'b0, 3'(rnd())}, 0, 0, 4'(i), 0, {i % 2 == 0, 2'b00});
      issue(i < 2 ? OP_POP : OP_POP_RET, AM_ABS, {1'b0, 3'(rnd())}, 0, 0, 4'(i), 0, {i % 2 == 0, 2'b00});
    end
    $display("stack done");
    for (int i = 0; i < 4; i++)
    begin
      issue(OP_JUMP_COND, AM_ABS, 0, {1'b0, 3'(rnd())}, 0, 0, 0, 3'(i % 2));
      issue(OP_JUMP_LINK, AM_ABS, 4'hc, {1'b0, 3'(rnd())}, 0, 0, 0, {1'b0, 1'(i), 1'b0});
    end
    issue(OP_JUMP_USER, AM_ABS, 0, 4'h3, 0, 0, 0, 0);
    issue(OP_EXC_RETURN, AM_ABS, 0, 0, 0, 0, 0, 0);
    $display("jump done");
    tally_and_finish();
  end
endmodule
